// >>> bench/psr_checker.sv
// bus assertions between master and sensor ends
`timescale 1ns/1ps
module psr_checker
    import psr_pkg::*;
#(
    parameter int HALF_CYCLES = SCL_HALF_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic scl_oe,
    input  wire logic sda_m_oe,
    input  wire logic sda_s_oe
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       scl_ff;
    logic       sda_ff;
    logic       frame_ff;
    logic [4:0] bit_ff;
    logic [7:0] adr_ff;
    int         hold_ff;
    logic       rise;
    logic       start;
    logic       stop;
    logic       rd_prim;
    assign rise    = scl && !scl_ff;
    assign start   = scl && scl_ff && sda_ff && !sda;
    assign stop    = scl && scl_ff && !sda_ff && sda;
    assign rd_prim = (adr_ff == {ADDR_PRIMARY, 1'b1});
    // frame, bit and address tracking
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            scl_ff   <= 1'b1;
            sda_ff   <= 1'b1;
            frame_ff <= 1'b0;
            bit_ff   <= 5'h00;
            adr_ff   <= 8'h00;
            hold_ff  <= 0;
        end else begin
            scl_ff   <= scl;
            sda_ff   <= sda;
            frame_ff <= start ? 1'b1 : (stop ? 1'b0 : frame_ff);
            hold_ff  <= (scl != scl_ff) ? 0 : hold_ff + 1;
            if (start) begin
                bit_ff <= 5'h00;
            end else if (rise) begin
                bit_ff <= bit_ff + 5'h01;
            end
            if (rise && bit_ff < 5'h08) begin
                adr_ff <= {adr_ff[6:0], sda};
            end
        end
    end
    a_sensor_data_steady:
        assert property (scl && scl_ff |-> $stable(sda_s_oe))
        else $error("sensor data moved while clock high");
    a_quiet_after_stop:
        assert property (stop |-> ##1 (!sda_s_oe && !scl_oe)[*4])
        else $error("line pulled low right after stop");
    a_drive_in_frame:
        assert property (sda_s_oe |-> frame_ff)
        else $error("sensor drove data outside a frame");
    a_addr_ack:
        assert property (rise && bit_ff == 5'h08 && rd_prim |-> !sda)
        else $error("primary address not acknowledged");
    a_addr_ignore:
        assert property (rise && bit_ff == 5'h08
            && adr_ff[7:1] != ADDR_PRIMARY
            && adr_ff[7:1] != ADDR_SECOND |-> sda)
        else $error("foreign address acknowledged");
    a_top_bit_zero:
        assert property (rise && bit_ff == 5'h09 && rd_prim |-> !sda)
        else $error("first data bit not zero");
    a_master_ack:
        assert property (rise && bit_ff == 5'h11 |-> !sda)
        else $error("first data byte not acknowledged");
    a_nack_release:
        assert property (rise && bit_ff == 5'h1A |-> sda ##1 (!sda_s_oe)[*8])
        else $error("sensor kept driving after nack");
    a_scl_low_min:
        assert property (rise |-> hold_ff >= HALF_CYCLES - 1)
        else $error("clock low phase too short");
    a_pulse_count:
        assert property (stop |-> bit_ff == 5'h0A || bit_ff == 5'h1C)
        else $error("wrong pulse count in frame");
    c_addr_ack: cover property (rise && bit_ff == 5'h08 && !sda);
    c_addr_nack: cover property (rise && bit_ff == 5'h08 && sda);
    c_full_read: cover property (stop && bit_ff == 5'h1C);
    c_master_ack: cover property (rise && bit_ff == 5'h11 && sda_m_oe);
endmodule

// >>> bench/testbench.sv
// master and sensor ends joined over the bus, self checking
`timescale 1ns/1ps
module testbench;
    import psr_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        req_i = 1'b0;
    logic [6:0]  addr_i = 7'h00;
    logic        data_ready_i = 1'b0;
    logic [14:0] press_i = 15'h1234;
    logic [14:0] press_val = 15'h1234;
    logic        busy_o;
    logic        second_en_i = 1'b0;
    logic        tog_en = 1'b0;
    logic        req_ready_o;
    logic        nack_o;
    logic [14:0] data_o;
    logic        data_valid_o;
    logic [14:0] press_o;
    logic        sc_q = 1'b1;
    logic        bitq[$];
    int          tg = 0;
    int          fails = 0;
    int          samples_checked = 0;
    psr_bus_if bus ();
    psr_sensor #(.REFRESH_CYCLES(20)) u_psr_sensor (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .bus(bus), .press_i(press_i),
        .second_en_i(second_en_i), .press_o(press_o), .busy_o(busy_o));
    psr_master #(.HALF_CYCLES(8)) u_psr_master (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .bus(bus), .req_i(req_i), .addr_i(addr_i),
        .req_ready_o(req_ready_o), .nack_o(nack_o), .data_o(data_o),
        .data_valid_o(data_valid_o), .data_ready_i(data_ready_i));
    psr_checker #(.HALF_CYCLES(8)) u_psr_checker (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .scl(bus.scl), .sda(bus.sda),
        .scl_oe(bus.scl_oe), .sda_m_oe(bus.sda_m_oe),
        .sda_s_oe(bus.sda_s_oe));
    always #25 clk_i = ~clk_i;
    // bit capture at each clock rise on the wire
    always @(negedge clk_i) begin
        sc_q <= bus.scl;
        if (bus.scl === 1'b1 && sc_q === 1'b0) begin
            bitq.push_back(bus.sda);
        end
    end
    // sample source, optionally kept moving
    always @(negedge clk_i) begin
        tg <= tg + 1;
        if (!tog_en) begin
            press_i <= press_val;
        end else if (tg % 3 == 0) begin
            press_i <= (press_i === 15'h7F00) ? 15'h00FF : 15'h7F00;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] byte_at(int s);
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            b = {b[6:0], bitq[s + i]};
        end
        return b;
    endfunction
    task automatic end_of_test();
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one request, then wait for the stop
    task automatic frame(input logic [6:0] a);
        logic p = 1'b1;
        logic seen = 1'b0;
        @(negedge clk_i);
        while (req_ready_o !== 1'b1) begin
            @(negedge clk_i);
        end
        addr_i = a;
        req_i = 1'b1;
        @(negedge clk_i);
        req_i = 1'b0;
        for (int i = 0; i < 3000 && !seen; i++) begin
            @(negedge clk_i);
            seen = bus.scl === 1'b1 && p === 1'b0 && bus.sda === 1'b1;
            p = bus.sda;
        end
        check(seen, 1'b1);
        repeat (6) @(negedge clk_i);
    endtask
    task automatic pop();
        data_ready_i = 1'b1;
        @(negedge clk_i);
        data_ready_i = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic rd(input logic [6:0] a, input logic nk,
                      input logic [14:0] d);
        bitq.delete();
        frame(a);
        check(busy_o, 1'b0);
        check(nack_o, nk);
        check(data_valid_o, !nk);
        if (!nk) begin
            check(data_o, d);
            pop();
        end
    endtask
    task automatic t_idle();
        check({bus.scl, bus.sda}, 2'b11);
        check(busy_o, 1'b0);
        check(press_o, PRESS_RST);
        check(req_ready_o, 1'b1);
    endtask
    task automatic t_refresh();
        press_val = 15'h5A3C;
        repeat (45) @(negedge clk_i);
        check(press_o, 15'h5A3C);
        check({bus.scl, bus.sda}, 2'b11);
    endtask
    task automatic t_primary();
        rd(ADDR_PRIMARY, 1'b0, 15'h5A3C);
        check(bitq.size(), 28);
        check(byte_at(0), {ADDR_PRIMARY, 1'b1});
        check(byte_at(9), 8'h5A);
        check(byte_at(18), 8'h3C);
        check({bitq[8], bitq[17], bitq[26]}, 3'b001);
    endtask
    task automatic t_addr();
        second_en_i = 1'b1;
        rd(ADDR_SECOND, 1'b0, 15'h5A3C);
        second_en_i = 1'b0;
        rd(ADDR_SECOND, 1'b1, 15'h0000);
        rd(7'h55, 1'b1, 15'h0000);
        check(bitq.size(), 10);
    endtask
    task automatic t_atomic();
        tog_en = 1'b1;
        frame(ADDR_PRIMARY);
        tog_en = 1'b0;
        check(data_o === 15'h7F00 || data_o === 15'h00FF, 1'b1);
        pop();
    endtask
    task automatic t_fifo();
        for (int i = 0; i < 8; i++) begin
            press_val = 15'h0100 + 15'(i);
            repeat (45) @(negedge clk_i);
            frame(ADDR_PRIMARY);
        end
        check(req_ready_o, 1'b0);
        for (int i = 0; i < 8; i++) begin
            check(data_valid_o, 1'b1);
            check(data_o, 15'h0100 + 15'(i));
            pop();
        end
        check(data_valid_o, 1'b0);
    endtask
    initial begin
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        t_idle();
        t_refresh();
        t_primary();
        t_addr();
        t_atomic();
        t_fifo();
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        fails++;
        end_of_test();
    end
endmodule

// >>> core/psr_bus_if.sv
// two-wire bus carrier between master and sensor
`timescale 1ns/1ps
interface psr_bus_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;
    // open drain wired and with pull-ups
    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe,
                    input scl, sda);
    modport sensor (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// >>> core/psr_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module psr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0]      cnt_ff, nxt_cnt;
    logic             push, pop;
    assign in_ready_o  = cnt_ff != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_ff != '0;
    assign out_data_o  = mem_ff[rd_ff];
    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;
    always_comb begin
        nxt_wr  = push ? AW'((wr_ff + 1'b1) % DEPTH) : wr_ff;
        nxt_rd  = pop ? AW'((rd_ff + 1'b1) % DEPTH) : rd_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= nxt_wr;
            rd_ff  <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
        if (push) begin
            mem_ff[wr_ff] <= in_data_i;
        end
    end
endmodule

// >>> core/psr_master.sv
// master end: clocks out address-read and stores readings in a fifo
`timescale 1ns/1ps
module psr_master
    import psr_pkg::*;
#(
    parameter int HALF_CYCLES = SCL_HALF_CYC,
    parameter int DEPTH       = FIFO_DEPTH
) (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    psr_bus_if.master               bus,
    input  wire logic               req_i,
    input  wire logic [6:0]         addr_i,
    output logic                    req_ready_o,
    output logic                    nack_o,
    output logic      [PRESS_W-1:0] data_o,
    output logic                    data_valid_o,
    input  wire logic               data_ready_i
);
    typedef enum logic [2:0] {
        MS_IDLE  = 3'b000,
        MS_START = 3'b001,
        MS_BITS  = 3'b010,
        MS_STOP  = 3'b011,
        MS_DONE  = 3'b100
    } psr_mst_t;
    psr_mst_t    st_ff, nxt_st;
    logic [15:0] div_ff, nxt_div;
    logic [1:0]  ph_ff, nxt_ph;
    logic [5:0]  idx_ff, nxt_idx;
    logic [26:0] pat_ff, nxt_pat;
    logic [15:0] rx_ff, nxt_rx;
    logic        sclh_ff, nxt_sclh, sdah_ff, nxt_sdah;
    logic        nack_ff, nxt_nack, push;
    logic        in_ready, tick;
    assign tick = div_ff == 16'(HALF_CYCLES - 1);
    // bit pattern: addr,R,ack(slave), 8 data, ack, 8 data, nack
    always_comb begin
        nxt_st   = st_ff;
        nxt_div  = tick ? 16'h0000 : div_ff + 16'h0001;
        nxt_ph   = ph_ff;
        nxt_idx  = idx_ff;
        nxt_pat  = pat_ff;
        nxt_rx   = rx_ff;
        nxt_sclh = sclh_ff;
        nxt_sdah = sdah_ff;
        nxt_nack = nack_ff;
        push     = 1'b0;
        unique case (st_ff)
            MS_IDLE: begin
                nxt_sclh = 1'b1;
                nxt_sdah = 1'b1;
                if (req_i && in_ready) begin
                    nxt_st   = MS_START;
                    nxt_div  = 16'h0000;
                    nxt_pat  = {addr_i, 1'b1, 1'b1, 8'hFF, 1'b0,
                                8'hFF, 1'b1};
                    nxt_nack = 1'b0;
                end
            end
            MS_START: if (tick) begin
                nxt_sdah = 1'b0;
                nxt_st   = MS_BITS;
                nxt_ph   = 2'h0;
                nxt_idx  = 6'h00;
            end
            MS_BITS: if (tick) begin
                nxt_ph = ph_ff + 2'h1;
                unique case (ph_ff)
                    2'h0: nxt_sclh = 1'b0;
                    2'h1: nxt_sdah = pat_ff[26];
                    2'h2: begin
                        nxt_sclh = 1'b1;
                        if (idx_ff != 6'h08 && idx_ff != 6'h11 &&
                            idx_ff != 6'h1A && idx_ff > 6'h08) begin
                            nxt_rx = {rx_ff[14:0], bus.sda};
                        end
                        if (idx_ff == 6'h08 && bus.sda) begin
                            nxt_nack = 1'b1;
                        end
                    end
                    default: begin
                        nxt_ph  = 2'h0;
                        nxt_pat = {pat_ff[25:0], 1'b1};
                        nxt_idx = idx_ff + 6'h01;
                        if (idx_ff == 6'h1A ||
                            (idx_ff == 6'h08 && nack_ff)) begin
                            nxt_st = MS_STOP;
                            nxt_ph = 2'h0;
                        end
                    end
                endcase
            end
            MS_STOP: if (tick) begin
                nxt_ph = ph_ff + 2'h1;
                unique case (ph_ff)
                    2'h0: nxt_sclh = 1'b0;
                    2'h1: nxt_sdah = 1'b0;
                    2'h2: nxt_sclh = 1'b1;
                    default: begin
                        nxt_sdah = 1'b1;
                        nxt_st   = MS_DONE;
                    end
                endcase
            end
            MS_DONE: begin
                push   = !nack_ff;
                nxt_st = MS_IDLE;
            end
            default: nxt_st = MS_IDLE;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_ff   <= MS_IDLE;
            div_ff  <= 16'h0000;
            ph_ff   <= 2'h0;
            idx_ff  <= 6'h00;
            pat_ff  <= '1;
            rx_ff   <= 16'h0000;
            sclh_ff <= 1'b1;
            sdah_ff <= 1'b1;
            nack_ff <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            div_ff  <= nxt_div;
            ph_ff   <= nxt_ph;
            idx_ff  <= nxt_idx;
            pat_ff  <= nxt_pat;
            rx_ff   <= nxt_rx;
            sclh_ff <= nxt_sclh;
            sdah_ff <= nxt_sdah;
            nack_ff <= nxt_nack;
        end
    end
    assign bus.scl_o    = 1'b0;
    assign bus.scl_oe   = !sclh_ff;
    assign bus.sda_m_o  = 1'b0;
    assign bus.sda_m_oe = !sdah_ff;
    assign req_ready_o  = st_ff == MS_IDLE && in_ready;
    assign nack_o       = nack_ff;
    psr_fifo #(.WIDTH(PRESS_W), .DEPTH(DEPTH)) u_fifo (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_data_i   (rx_ff[PRESS_W-1:0]),
        .in_valid_i  (push),
        .in_ready_o  (in_ready),
        .out_data_o  (data_o),
        .out_valid_o (data_valid_o),
        .out_ready_i (data_ready_i)
    );
endmodule

// >>> core/psr_pkg.sv
// shared constants for the pressure readout link
package psr_pkg;
    localparam int        CLK_HZ         = 20_000_000;
    localparam int        REFRESH_US     = 250;
    localparam int        REFRESH_CYC    = CLK_HZ / 1_000_000 * REFRESH_US;
    localparam int        SCL_MAX_KHZ    = 400;
    localparam int        SCL_HALF_CYC   = (CLK_HZ / 1000 + 2 * SCL_MAX_KHZ - 1)
                                           / (2 * SCL_MAX_KHZ);
    localparam logic [6:0] ADDR_PRIMARY  = 7'h78;
    localparam logic [6:0] ADDR_SECOND   = 7'h79;
    localparam int        PRESS_W        = 15;
    localparam int        BYTE_W         = 8;
    localparam int        FIFO_DEPTH     = 8;
    localparam logic [14:0] PRESS_RST    = 15'h0000;
endpackage

// >>> core/psr_sensor.sv
// sensor end: cyclic pressure refresh and two-wire slave readout
`timescale 1ns/1ps
// Contract
// - refresh pressure value every 250 us, independently
// - release both lines while bus idle
// - detect SDA fall with SCL high as start
// - master opens each request with start
// - detect SDA rise with SCL high as stop
// - accept repeated start without stop
// - change SDA only while SCL low
// - one SCL pulse per bit
// - bytes of eight bits, MSB first
// - receiver pulls SDA low to acknowledge
// - master nack ends sensor transmission
// - after nack master repeats or stops
// - answer primary address 1111000
// - also answer enabled secondary address
// - master sends address plus direction bit
// - read returns two bytes of 15-bit value
// - sensor is slave only, never clocks
// - master SCL at most 400 kHz
module psr_sensor
    import psr_pkg::*;
#(
    parameter int          REFRESH_CYCLES = REFRESH_CYC,
    parameter logic [6:0]  SECOND_ADDR    = ADDR_SECOND
) (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    psr_bus_if.sensor               bus,
    input  wire logic [PRESS_W-1:0] press_i,
    input  wire logic               second_en_i,
    output logic      [PRESS_W-1:0] press_o,
    output logic                    busy_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_SEND = 3'b011,
        ST_MACK = 3'b100,
        ST_RECV = 3'b101,
        ST_WACK = 3'b110
    } psr_state_t;
    psr_state_t       st_ff, nxt_st;
    logic [2:0]       scl_sy_ff, sda_sy_ff;
    logic             scl_ff, sda_ff, nxt_scl, nxt_sda;
    logic [PRESS_W-1:0] out_ff, nxt_out;
    logic [15:0]      tim_ff, nxt_tim;
    logic [7:0]       sh_ff, nxt_sh;
    logic [2:0]       bit_ff, nxt_bit;
    logic             byte_ff, nxt_byte;
    logic [7:0]       snap_ff, nxt_snap;
    logic             drv_ff, nxt_drv;
    logic             scl_rise, scl_fall, start_c, stop_c;
    // three-stage sync; change counts when stages 2 and 3 agree
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            scl_sy_ff <= 3'h7;
            sda_sy_ff <= 3'h7;
        end else begin
            scl_sy_ff <= {scl_sy_ff[1:0], bus.scl};
            sda_sy_ff <= {sda_sy_ff[1:0], bus.sda};
        end
    end
    always_comb begin
        nxt_scl = (scl_sy_ff[2] == scl_sy_ff[1]) ? scl_sy_ff[2] : scl_ff;
        nxt_sda = (sda_sy_ff[2] == sda_sy_ff[1]) ? sda_sy_ff[2] : sda_ff;
    end
    assign scl_rise = nxt_scl && !scl_ff;
    assign scl_fall = !nxt_scl && scl_ff;
    assign start_c  = scl_ff && nxt_scl && sda_ff && !nxt_sda;
    assign stop_c   = scl_ff && nxt_scl && !sda_ff && nxt_sda;
    // cyclic refresh of output value
    always_comb begin
        nxt_tim = tim_ff + 16'h0001;
        nxt_out = out_ff;
        if (tim_ff >= 16'(REFRESH_CYCLES - 1)) begin
            nxt_tim = 16'h0000;
            nxt_out = press_i;
        end
    end
    // bit/byte engine, slave only, acts on sampled SCL edges
    always_comb begin
        nxt_st   = st_ff;
        nxt_sh   = sh_ff;
        nxt_bit  = bit_ff;
        nxt_byte = byte_ff;
        nxt_snap = snap_ff;
        nxt_drv  = drv_ff;
        if (start_c) begin
            nxt_st   = ST_ADDR;
            nxt_bit  = 3'h0;
            nxt_drv  = 1'b0;
            nxt_byte = 1'b0;
        end else if (stop_c) begin
            nxt_st  = ST_IDLE;
            nxt_drv = 1'b0;
        end else if (scl_rise) begin
            unique case (st_ff)
                ST_ADDR, ST_RECV: begin
                    nxt_sh   = {sh_ff[6:0], sda_ff};
                    nxt_bit  = bit_ff + 3'h1;
                    nxt_byte = 1'b1;
                end
                ST_MACK: begin
                    if (sda_ff || byte_ff) begin
                        nxt_st = ST_IDLE;
                    end
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            unique case (st_ff)
                ST_ADDR: begin
                    // skip the fall that follows the start itself
                    if (bit_ff == 3'h0 && byte_ff) begin
                        if (sh_ff[7:1] == ADDR_PRIMARY ||
                            (second_en_i && sh_ff[7:1] == SECOND_ADDR)) begin
                            nxt_st  = ST_AACK;
                            nxt_drv = 1'b1;
                        end else begin
                            nxt_st = ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    if (sh_ff[0]) begin
                        nxt_snap = out_ff[7:0];
                        nxt_st   = ST_SEND;
                        nxt_byte = 1'b0;
                        nxt_drv  = 1'b1;
                        nxt_sh   = {out_ff[14:8], 1'b0};
                    end else begin
                        nxt_st  = ST_RECV;
                        nxt_drv = 1'b0;
                    end
                    nxt_bit = 3'h0;
                end
                ST_SEND: begin
                    nxt_bit = bit_ff + 3'h1;
                    if (bit_ff == 3'h7) begin
                        nxt_st  = ST_MACK;
                        nxt_drv = 1'b0;
                    end else begin
                        nxt_drv = !sh_ff[7];
                        nxt_sh  = {sh_ff[6:0], 1'b0};
                    end
                end
                ST_MACK: begin
                    nxt_st   = ST_SEND;
                    nxt_byte = 1'b1;
                    nxt_bit  = 3'h0;
                    nxt_drv  = !snap_ff[7];
                    nxt_sh   = {snap_ff[6:0], 1'b0};
                end
                ST_RECV: begin
                    if (bit_ff == 3'h0) begin
                        nxt_st  = ST_WACK;
                        nxt_drv = 1'b1;
                    end
                end
                ST_WACK: begin
                    nxt_st  = ST_RECV;
                    nxt_drv = 1'b0;
                end
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            scl_ff  <= 1'b1;
            sda_ff  <= 1'b1;
            tim_ff  <= 16'h0000;
            out_ff  <= PRESS_RST;
            st_ff   <= ST_IDLE;
            sh_ff   <= 8'h00;
            bit_ff  <= 3'h0;
            byte_ff <= 1'b0;
            snap_ff <= 8'h00;
            drv_ff  <= 1'b0;
        end else begin
            scl_ff  <= nxt_scl;
            sda_ff  <= nxt_sda;
            tim_ff  <= nxt_tim;
            out_ff  <= nxt_out;
            st_ff   <= nxt_st;
            sh_ff   <= nxt_sh;
            bit_ff  <= nxt_bit;
            byte_ff <= nxt_byte;
            snap_ff <= nxt_snap;
            drv_ff  <= nxt_drv;
        end
    end
    // open drain: only ever pull low
    assign bus.sda_s_o  = 1'b0;
    assign bus.sda_s_oe = drv_ff;
    assign press_o      = out_ff;
    assign busy_o       = st_ff != ST_IDLE;
endmodule
